// [hdl/eeprom_config_loader.sv]
`timescale 1ns/1ps
`default_nettype none
//
// Contract
// [RULE1] only eight-bit addressed eeproms; one address byte per access
// [RULE2] after reset with autoload on, read byte 00h and compare with AAh
// [RULE3] on match read from byte 01h, four bytes per config dword upward
// [RULE4] target answers retry while loading runs
// [RULE5] signature mismatch stops loading; defaults kept, no retry
// [RULE6] autoload pin low skips loading; accesses accepted after reset
// [RULE7] software sets byte address before read or write
// [RULE8] software sets data byte before write status or write memory
// [RULE9] go bit written to one starts the decoded command
// [RULE10] controller clears go when done; software polls it
// [RULE11] read result stays in data field once go clears
// [RULE12] no presence check for software transactions
// [RULE13] read: select low, instruction, address, data in, select high
// [RULE14] write enable instruction issued alone before any write
// [RULE15] write: instruction, address, data; deselect right after D0
// [RULE16] go stays set during the write cycle, cleared at its end
// [RULE17] serial clock generated here, msb first, opposite-edge sampling
//
module eeprom_config_loader
  import eeprom_loader_pkg::*;
#(
  parameter int LOAD_DWORDS = 16,
  parameter int HALF_DIV    = HALF_DIV_CYC
)(
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        reset_i,
  // straps
  input  wire logic        autoload_enable_pin_i,
  // serial eeprom
  output logic             eeprom_select_n_o,
  output logic             eeprom_sck_o,
  output logic             eeprom_serial_out_o,
  input  wire logic        eeprom_serial_in_i,
  // configuration space load port
  output logic             cfg_wr_o,
  output logic [7:0]       cfg_addr_o,
  output logic [31:0]      cfg_data_o,
  output logic             cfg_retry_o,
  // eeprom control register fields
  input  wire logic        ctrl_wr_i,
  input  wire logic        ctrl_go_i,
  input  wire logic [2:0]  ctrl_cmd_i,
  input  wire logic [7:0]  ctrl_addr_i,
  input  wire logic [7:0]  ctrl_data_i,
  output logic             ctrl_go_o,
  output logic [7:0]       ctrl_data_o
);

  // the whole load must fit in the eight-bit eeprom space after the signature
  if (LOAD_DWORDS < 1 || LOAD_DWORDS * 4 > 255)
  begin : g_load_check
    $error("LOAD_DWORDS out of range");
  end

  typedef enum logic [2:0] {
    M_BOOT, M_SIG, M_LOAD, M_IDLE, M_WRITE_LATCH_ENABLE_INSTR, M_CMD, M_POLL
  } main_state_t;

  shift_if sh ();

  main_state_t st_q, st_d;
  logic        issued_q, issued_d;
  logic [7:0]  eaddr_q, eaddr_d;
  logic [1:0]  lane_q, lane_d;
  logic [7:0]  caddr_q, caddr_d;
  logic [31:0] dword_q, dword_d;
  logic [31:0] cfg_data_q, cfg_data_d;
  logic [7:0]  cfg_addr_q, cfg_addr_d;
  logic        cfg_wr_q, cfg_wr_d;
  logic        go_q, go_d;
  logic [2:0]  cmd_q, cmd_d;
  logic [7:0]  addr_q, addr_d;
  logic [7:0]  data_q, data_d;
  logic [1:0]  boot_q, boot_d;
  logic [SYNC_STAGES-1:0] load_sync_q;
  logic        load_en;

  // true for commands that store into the eeprom
  function automatic logic is_write(input logic [2:0] c);
    return (c == CMD_WRITE_STATUS) || (c == CMD_WRITE_MEM);
  endfunction

  // ****************************************
  // strap synchroniser
  // ****************************************
  always_ff @(posedge clk_i or posedge reset_i)
    if (reset_i)
      load_sync_q <= '0;
    else
      load_sync_q <= {load_sync_q[SYNC_STAGES-2:0], autoload_enable_pin_i};

  assign load_en = load_sync_q[SYNC_STAGES-1];

  // ****************************************
  // request to the shift engine
  // ****************************************
  always_comb
  begin
    sh.start   = 1'b0;
    sh.tx_word = 24'h000000;
    sh.n_out   = 2'h1;
    sh.rd      = 1'b0;
    if (!issued_q)
    begin
      case (st_q)
        M_SIG, M_LOAD:
        begin
          sh.start   = 1'b1;
          sh.tx_word = {OP_READ_MEM, eaddr_q, 8'h00};
          sh.n_out   = 2'h2;
          sh.rd      = 1'b1;
        end
        // [RULE14] write enable sent on its own
        M_WRITE_LATCH_ENABLE_INSTR:
        begin
          sh.start   = 1'b1;
          sh.tx_word = {OP_WRITE_EN, 16'h0000};
        end
        M_POLL:
        begin
          sh.start   = 1'b1;
          sh.tx_word = {OP_READ_STATUS, 16'h0000};
          sh.rd      = 1'b1;
        end
        // [RULE9] decode the command field
        M_CMD:
        begin
          sh.start = 1'b1;
          case (cmd_q)
            CMD_WRITE_STATUS:
            begin
              sh.tx_word = {OP_WRITE_STATUS, data_q, 8'h00};
              sh.n_out   = 2'h2;
            end
            CMD_WRITE_MEM:
            begin
              sh.tx_word = {OP_WRITE_MEM, addr_q, data_q};
              sh.n_out   = 2'h3;
            end
            CMD_READ_MEM:
            begin
              sh.tx_word = {OP_READ_MEM, addr_q, 8'h00};
              sh.n_out   = 2'h2;
              sh.rd      = 1'b1;
            end
            CMD_READ_STATUS:
            begin
              sh.tx_word = {OP_READ_STATUS, 16'h0000};
              sh.rd      = 1'b1;
            end
            CMD_WRITE_EN:
              sh.tx_word = {OP_WRITE_EN, 16'h0000};
            default:
              sh.tx_word = {OP_WRITE_DIS, 16'h0000};
          endcase
        end
        default:
          sh.start = 1'b0;
      endcase
    end
  end

  // ****************************************
  // main sequencer
  // ****************************************
  always_comb
  begin
    st_d       = st_q;
    issued_d   = issued_q;
    eaddr_d    = eaddr_q;
    lane_d     = lane_q;
    caddr_d    = caddr_q;
    dword_d    = dword_q;
    cfg_data_d = cfg_data_q;
    cfg_addr_d = cfg_addr_q;
    cfg_wr_d   = 1'b0;
    go_d       = go_q;
    cmd_d      = cmd_q;
    addr_d     = addr_q;
    data_d     = data_q;
    boot_d     = boot_q;
    if (sh.start)
      issued_d = 1'b1;
    if (sh.done)
      issued_d = 1'b0;
    // [RULE7] [RULE8] fields are taken with the go write
    if (ctrl_wr_i && !go_q)
    begin
      cmd_d  = ctrl_cmd_i;
      addr_d = ctrl_addr_i;
      data_d = ctrl_data_i;
      go_d   = ctrl_go_i;
    end
    case (st_q)
      M_BOOT:
      begin
        boot_d = boot_q + 2'h1;
        if (boot_q == 2'(SYNC_STAGES))
        begin
          // [RULE6] strap low skips loading
          // [RULE2] first read is the signature
          eaddr_d = SIG_ADDR;
          st_d    = load_en ? M_SIG : M_IDLE;
        end
      end
      M_SIG:
        if (sh.done)
        begin
          // [RULE5] mismatch ends loading at once
          eaddr_d = LOAD_FIRST_ADDR;
          lane_d  = 2'h0;
          caddr_d = CFG_FIRST_ADDR;
          st_d    = (sh.rx_byte == SIG_VALUE) ? M_LOAD : M_IDLE;
        end
      M_LOAD:
        if (sh.done)
        begin
          // [RULE3] first byte lands in the low lane
          dword_d = {sh.rx_byte, dword_q[31:8]};
          eaddr_d = eaddr_q + BYTE_STEP;
          lane_d  = lane_q + 2'h1;
          if (lane_q == LAST_LANE)
          begin
            cfg_wr_d   = 1'b1;
            cfg_data_d = {sh.rx_byte, dword_q[31:8]};
            cfg_addr_d = caddr_q;
            caddr_d    = caddr_q + CFG_DWORD_STEP;
            if (caddr_q == 8'((LOAD_DWORDS - 1) * 4))
              st_d = M_IDLE;
          end
        end
      M_IDLE:
        // [RULE12] no presence check, just run it
        if (go_q)
          st_d = is_write(cmd_q) ? M_WRITE_LATCH_ENABLE_INSTR : M_CMD;
      M_WRITE_LATCH_ENABLE_INSTR:
        if (sh.done)
          st_d = M_CMD;
      M_CMD:
        if (sh.done)
        begin
          // [RULE11] keep the received byte
          if (cmd_q == CMD_READ_MEM || cmd_q == CMD_READ_STATUS)
            data_d = sh.rx_byte;
          if (is_write(cmd_q))
            st_d = M_POLL;
          else
          begin
            // [RULE10] go cleared at completion
            go_d = 1'b0;
            st_d = M_IDLE;
          end
        end
      M_POLL:
        // [RULE16] go holds until the part reports the write cycle over
        if (sh.done && !sh.rx_byte[BUSY_BIT])
        begin
          go_d = 1'b0;
          st_d = M_IDLE;
        end
      default:
        st_d = M_IDLE;
    endcase
  end

  always_ff @(posedge clk_i or posedge reset_i)
    if (reset_i)
    begin
      st_q       <= M_BOOT;
      issued_q   <= 1'b0;
      eaddr_q    <= SIG_ADDR;
      lane_q     <= 2'h0;
      caddr_q    <= CFG_FIRST_ADDR;
      dword_q    <= 32'h0000_0000;
      cfg_data_q <= 32'h0000_0000;
      cfg_addr_q <= 8'h00;
      cfg_wr_q   <= 1'b0;
      go_q       <= 1'b0;
      cmd_q      <= 3'h0;
      addr_q     <= 8'h00;
      data_q     <= 8'h00;
      boot_q     <= 2'h0;
    end
    else
    begin
      st_q       <= st_d;
      issued_q   <= issued_d;
      eaddr_q    <= eaddr_d;
      lane_q     <= lane_d;
      caddr_q    <= caddr_d;
      dword_q    <= dword_d;
      cfg_data_q <= cfg_data_d;
      cfg_addr_q <= cfg_addr_d;
      cfg_wr_q   <= cfg_wr_d;
      go_q       <= go_d;
      cmd_q      <= cmd_d;
      addr_q     <= addr_d;
      data_q     <= data_d;
      boot_q     <= boot_d;
    end

  eeprom_shift_engine #(
    .HALF_DIV (HALF_DIV)
  ) u_engine (
    .clk_i               (clk_i),
    .reset_i             (reset_i),
    .req                 (sh.eng),
    .eeprom_select_n_o   (eeprom_select_n_o),
    .eeprom_sck_o        (eeprom_sck_o),
    .eeprom_serial_out_o (eeprom_serial_out_o),
    .eeprom_serial_in_i  (eeprom_serial_in_i)
  );

  // [RULE4] retry from reset until loading is over
  assign cfg_retry_o = (st_q == M_BOOT) || (st_q == M_SIG) || (st_q == M_LOAD);
  assign cfg_wr_o    = cfg_wr_q;
  assign cfg_addr_o  = cfg_addr_q;
  assign cfg_data_o  = cfg_data_q;
  assign ctrl_go_o   = go_q;
  assign ctrl_data_o = data_q;

endmodule // eeprom_config_loader
`default_nettype wire

// [hdl/eeprom_loader_pkg.sv]
package eeprom_loader_pkg;

  // ****************************************
  // signature and load addresses
  // ****************************************
  localparam logic [7:0] SIG_ADDR        = 8'h00;
  localparam logic [7:0] SIG_VALUE       = 8'hAA;
  localparam logic [7:0] LOAD_FIRST_ADDR = 8'h01;
  localparam logic [7:0] CFG_FIRST_ADDR  = 8'h00;
  localparam logic [7:0] CFG_DWORD_STEP  = 8'h04;
  localparam logic [7:0] BYTE_STEP       = 8'h01;
  localparam logic [1:0] LAST_LANE       = 2'h3;

  // ****************************************
  // serial eeprom instructions
  // ****************************************
  localparam logic [7:0] OP_WRITE_STATUS = 8'h01;
  localparam logic [7:0] OP_WRITE_MEM    = 8'h02;
  localparam logic [7:0] OP_READ_MEM     = 8'h03;
  localparam logic [7:0] OP_WRITE_DIS    = 8'h04;
  localparam logic [7:0] OP_READ_STATUS  = 8'h05;
  localparam logic [7:0] OP_WRITE_EN     = 8'h06;
  localparam int         BUSY_BIT        = 0;

  // ****************************************
  // software command field codes
  // ****************************************
  localparam logic [2:0] CMD_WRITE_STATUS = 3'h0;
  localparam logic [2:0] CMD_WRITE_MEM    = 3'h1;
  localparam logic [2:0] CMD_READ_MEM     = 3'h2;
  localparam logic [2:0] CMD_READ_STATUS  = 3'h3;
  localparam logic [2:0] CMD_WRITE_EN     = 3'h4;
  localparam logic [2:0] CMD_WRITE_DIS    = 3'h5;

  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_PERIOD_NS  = 100;
  localparam int LINK_PERIOD_NS = 800;
  // half serial period, least time, rounded up
  localparam int HALF_DIV_CYC   =
    (LINK_PERIOD_NS + 2 * CLK_PERIOD_NS - 1) / (2 * CLK_PERIOD_NS);
  localparam int SYNC_STAGES    = 2;
  localparam int BYTE_BITS      = 8;

endpackage

// [hdl/shift_if.sv]
`timescale 1ns/1ps
`default_nettype none
// one serial transaction request from the controller to the shift engine
interface shift_if;
  logic        start;
  logic [23:0] tx_word;
  logic [1:0]  n_out;
  logic        rd;
  logic        busy;
  logic        done;
  logic [7:0]  rx_byte;

  modport ctrl (output start, output tx_word, output n_out, output rd,
                input busy, input done, input rx_byte);
  modport eng  (input start, input tx_word, input n_out, input rd,
                output busy, output done, output rx_byte);
endinterface
`default_nettype wire

// [hdl/eeprom_shift_engine.sv]
`timescale 1ns/1ps
`default_nettype none
module eeprom_shift_engine
  import eeprom_loader_pkg::*;
#(
  parameter int HALF_DIV = HALF_DIV_CYC
)(
  // clock and reset
  input  wire logic clk_i,
  input  wire logic reset_i,
  // request side
  shift_if.eng      req,
  // serial eeprom pins
  output logic      eeprom_select_n_o,
  output logic      eeprom_sck_o,
  output logic      eeprom_serial_out_o,
  input  wire logic eeprom_serial_in_i
);

  // sampling uses the synchronised input, so it needs the sync delay
  if (HALF_DIV < SYNC_STAGES + 1 || HALF_DIV > 65536)
  begin : g_div_check
    $error("HALF_DIV out of range");
  end

  typedef enum logic [1:0] {E_IDLE, E_SEL, E_BITS, E_END} eng_state_t;

  eng_state_t  st_q, st_d;
  logic [31:0] tx_q, tx_d;
  logic [7:0]  rx_q, rx_d;
  logic [5:0]  cnt_q, cnt_d;
  logic [5:0]  total_q, total_d;
  logic        sck_q, sck_d;
  logic        done_q, done_d;
  logic [15:0] div_q, div_d;
  logic        tick;
  logic [SYNC_STAGES-1:0] sin_sync_q;

  // ****************************************
  // divider and input synchroniser
  // ****************************************
  assign tick  = (div_q == 16'(HALF_DIV - 1));
  assign div_d = tick ? 16'h0000 : div_q + 16'h0001;

  always_ff @(posedge clk_i or posedge reset_i)
    if (reset_i)
    begin
      div_q      <= 16'h0000;
      sin_sync_q <= '0;
    end
    else
    begin
      div_q      <= div_d;
      sin_sync_q <= {sin_sync_q[SYNC_STAGES-2:0], eeprom_serial_in_i};
    end

  // ****************************************
  // shift sequencer
  // ****************************************
  always_comb
  begin
    st_d    = st_q;
    tx_d    = tx_q;
    rx_d    = rx_q;
    cnt_d   = cnt_q;
    total_d = total_q;
    sck_d   = sck_q;
    done_d  = 1'b0;
    case (st_q)
      E_IDLE:
        if (req.start)
        begin
          tx_d    = {req.tx_word, 8'h00};
          // [RULE1] one address byte
          total_d = 6'(BYTE_BITS * (int'(req.n_out) + (req.rd ? 1 : 0)));
          cnt_d   = 6'h00;
          st_d    = E_SEL;
        end
      E_SEL:
        if (tick)
          st_d = E_BITS;
      E_BITS:
        if (tick)
        begin
          // [RULE17] msb first, sample on fall
          if (!sck_q)
            sck_d = 1'b1;
          else
          begin
            sck_d = 1'b0;
            rx_d  = {rx_q[6:0], sin_sync_q[SYNC_STAGES-1]};
            tx_d  = {tx_q[30:0], 1'b0};
            cnt_d = cnt_q + 6'h01;
            // [RULE15] deselect right after D0
            if (cnt_q == total_q - 6'h01)
              st_d = E_END;
          end
        end
      E_END:
        if (tick)
        begin
          done_d = 1'b1;
          st_d   = E_IDLE;
        end
      default:
        st_d = E_IDLE;
    endcase
  end

  always_ff @(posedge clk_i or posedge reset_i)
    if (reset_i)
    begin
      st_q    <= E_IDLE;
      tx_q    <= 32'h0000_0000;
      rx_q    <= 8'h00;
      cnt_q   <= 6'h00;
      total_q <= 6'h00;
      sck_q   <= 1'b0;
      done_q  <= 1'b0;
    end
    else
    begin
      st_q    <= st_d;
      tx_q    <= tx_d;
      rx_q    <= rx_d;
      cnt_q   <= cnt_d;
      total_q <= total_d;
      sck_q   <= sck_d;
      done_q  <= done_d;
    end

  // [RULE13] select low through the sequence
  assign eeprom_select_n_o   = !(st_q == E_SEL || st_q == E_BITS);
  assign eeprom_sck_o        = sck_q;
  assign eeprom_serial_out_o = tx_q[31];
  assign req.busy            = (st_q != E_IDLE) || done_q;
  assign req.done            = done_q;
  assign req.rx_byte         = rx_q;

endmodule // eeprom_shift_engine
`default_nettype wire

// [dv/eeprom_loader_asserts.sv]
`timescale 1ns/1ps
`default_nettype none
module eeprom_loader_asserts #(
  parameter int LOAD_DWORDS = 16,
  parameter int HALF_DIV    = 4
)(
  // clock, reset, strap
  input wire logic        clk_i,
  input wire logic        reset_i,
  input wire logic        autoload_enable_pin_i,
  // serial eeprom
  input wire logic        eeprom_select_n_o,
  input wire logic        eeprom_sck_o,
  input wire logic        eeprom_serial_out_o,
  input wire logic        eeprom_serial_in_i,
  // config load port
  input wire logic        cfg_wr_o,
  input wire logic [7:0]  cfg_addr_o,
  input wire logic [31:0] cfg_data_o,
  input wire logic        cfg_retry_o,
  // control register
  input wire logic        ctrl_wr_i,
  input wire logic        ctrl_go_i,
  input wire logic [2:0]  ctrl_cmd_i,
  input wire logic [7:0]  ctrl_addr_i,
  input wire logic [7:0]  ctrl_data_i,
  input wire logic        ctrl_go_o,
  input wire logic [7:0]  ctrl_data_o
);
  logic [3:0] rel_q;
  logic [3:0] rel_d;

  // saturating count of edges since reset release
  always_comb rel_d = (rel_q == 4'hF) ? rel_q : rel_q + 4'h1;
  always_ff @(posedge clk_i or posedge reset_i)
    if (reset_i)
      rel_q <= 4'h0;
    else
      rel_q <= rel_d;

  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i);

  a_strap_low_skip: assert property (
    !autoload_enable_pin_i && rel_q == 4'h6 |-> !cfg_retry_o) else $error("retry kept");
  a_retry_no_return: assert property (
    !cfg_retry_o |=> !cfg_retry_o) else $error("retry came back");
  a_cfg_dword_align: assert property (
    cfg_wr_o |-> cfg_addr_o[1:0] == 2'h0 ##1 !cfg_wr_o) else $error("bad cfg write");
  a_sck_idle_low: assert property (
    eeprom_select_n_o |-> !eeprom_sck_o) else $error("sck off idle");
  a_lead_low_time: assert property (
    $fell(eeprom_select_n_o) |-> !eeprom_sck_o [*3]) else $error("early sck");
  a_go_takes_write: assert property (
    ctrl_wr_i && !ctrl_go_o |=> ctrl_go_o == $past(ctrl_go_i)) else $error("go not taken");
  a_go_busy_select: assert property (
    !eeprom_select_n_o && !cfg_retry_o |-> ctrl_go_o) else $error("go low in frame");
  a_go_clear_idle: assert property (
    $fell(ctrl_go_o) |-> eeprom_select_n_o && $past(eeprom_select_n_o, 3))
    else $error("go cleared early");
  a_read_data_holds: assert property (
    !ctrl_go_o && !ctrl_wr_i |=> $stable(ctrl_data_o)) else $error("data moved");

  cover property (cfg_wr_o);
  cover property ($fell(ctrl_go_o));
  cover property ($fell(cfg_retry_o));
endmodule // eeprom_loader_asserts
`default_nettype wire

// [dv/spi_eeprom_model.sv]
`timescale 1ns/1ps
`default_nettype none
module spi_eeprom_model (
  // eeprom pins
  input  wire logic select_n_i,
  input  wire logic sck_i,
  input  wire logic serial_i,
  // bench control: no part fitted, line pulled high
  input  wire logic absent_i,
  output logic      serial_o
);
  logic [7:0] mem [256];
  logic [7:0] ins;
  logic [7:0] adr;
  logic [7:0] sh;
  logic [7:0] out;
  logic       wel;
  logic       tx;
  int         n;
  int         busy;

  initial
  begin
    for (int i = 0; i < 256; i++)
      mem[i] = 8'h5A ^ 8'(i);
    wel = 1'b0;
    tx = 1'b0;
    busy = 0;
    serial_o = 1'b1;
  end

  always @(negedge select_n_i)
  begin
    n = 0;
    tx = 1'b0;
  end

  always @(posedge sck_i)
    if (!select_n_i)
    begin
      sh = {sh[6:0], serial_i};
      n++;
      if (n == 8)
        ins = sh;
      if (n == 8 && ins == 8'h06)
        wel = 1'b1;
      if (n == 8 && ins == 8'h04)
        wel = 1'b0;
      if (n == 8 && ins == 8'h05)
      begin
        out = {7'h00, busy != 0};
        tx = 1'b1;
        if (busy > 0)
          busy--;
      end
      if (n == 16)
        adr = sh;
      if (n == 16 && ins == 8'h03)
      begin
        out = mem[adr];
        tx = 1'b1;
      end
    end

  always @(negedge sck_i)
    if (!select_n_i && tx)
    begin
      serial_o = absent_i | out[7];
      out = {out[6:0], 1'b0};
    end

  // released line shows the inverse of its last level
  always @(posedge select_n_i)
  begin
    serial_o = absent_i | ~serial_o;
    // writes need the latch and use it up
    if (wel && ((ins == 8'h02 && n == 24) || (ins == 8'h01 && n == 16)))
    begin
      if (ins == 8'h02)
        mem[adr] = sh;
      busy = 2;
      wel = 1'b0;
    end
  end
endmodule // spi_eeprom_model
`default_nettype wire

// [dv/eeprom_config_loader_tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module eeprom_config_loader_tb_top
  import eeprom_loader_pkg::*;
;
  localparam int LOAD_DWORDS = 2;
  localparam int HALF_DIV    = 4;
  logic        clk_i = 1'b0;
  logic        reset_i = 1'b1;
  logic        autoload_enable_pin_i = 1'b0;
  logic        eeprom_select_n_o, eeprom_sck_o, eeprom_serial_out_o, eeprom_serial_in_i;
  logic        cfg_wr_o, cfg_retry_o, ctrl_go_o;
  logic [7:0]  cfg_addr_o, ctrl_data_o;
  logic [31:0] cfg_data_o;
  logic        ctrl_wr_i = 1'b0;
  logic        ctrl_go_i = 1'b0;
  logic [2:0]  ctrl_cmd_i = 3'h0;
  logic [7:0]  ctrl_addr_i = 8'h00;
  logic [7:0]  ctrl_data_i = 8'h00;
  logic        absent = 1'b0;
  logic [7:0]  fb;
  logic [23:0] fsh;
  logic [23:0] frames[$];
  logic [39:0] cfg_q[$];
  int          miscompares = 0;
  int          check_count = 0;
  int          cycles = 0;

  always #50 clk_i = ~clk_i;

  eeprom_config_loader #(.LOAD_DWORDS(LOAD_DWORDS), .HALF_DIV(HALF_DIV)) DUT (
    .clk_i, .reset_i, .autoload_enable_pin_i, .eeprom_select_n_o, .eeprom_sck_o,
    .eeprom_serial_out_o, .eeprom_serial_in_i, .cfg_wr_o, .cfg_addr_o, .cfg_data_o,
    .cfg_retry_o, .ctrl_wr_i, .ctrl_go_i, .ctrl_cmd_i, .ctrl_addr_i, .ctrl_data_i,
    .ctrl_go_o, .ctrl_data_o);

  spi_eeprom_model mdl (.select_n_i(eeprom_select_n_o), .sck_i(eeprom_sck_o),
    .serial_i(eeprom_serial_out_o), .absent_i(absent), .serial_o(eeprom_serial_in_i));

  // ****************************************
  // wire monitors
  // ****************************************
  always @(negedge eeprom_select_n_o)
  begin
    fb = 8'h00;
    fsh = 24'h0;
  end
  always @(posedge eeprom_sck_o)
    if (!eeprom_select_n_o)
    begin
      fb = fb + 8'h01;
      fsh = {fsh[22:0], eeprom_serial_out_o};
    end
  always @(posedge eeprom_select_n_o)
    frames.push_back({fb, 8'(fsh >> (fb - 8'h08)), (fb == 8'h18) ? fsh[15:8] : 8'h00});
  always @(posedge clk_i)
  begin
    if (cfg_wr_o === 1'b1)
      cfg_q.push_back({cfg_addr_o, cfg_data_o});
    cycles++;
    if (cycles == 40000)
    begin
      miscompares++;
      close_out();
    end
  end

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [23:0] fr(input logic [7:0] b, input logic [7:0] op,
                                     input logic [7:0] a);
    return {b, op, a};
  endfunction

  // wide enough for an address and a dword together
  task automatic check(input logic [39:0] got, input logic [39:0] exp);
    check_count++;
    if (got !== exp)
    begin
      miscompares++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic close_out();
    $display("checks %0d miscompares %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic do_reset(input logic strap);
    @(posedge clk_i);
    reset_i <= 1'b1;
    autoload_enable_pin_i <= strap;
    repeat (12) @(posedge clk_i);
    reset_i <= 1'b0;
    frames.delete();
    cfg_q.delete();
  endtask

  task automatic wait_idle(input bit go);
    int k;
    k = 0;
    do
    begin
      @(posedge clk_i);
      #1;
      k++;
    end while ((go ? ctrl_go_o : cfg_retry_o) === 1'b1 && k < 9000);
    check(go ? ctrl_go_o : cfg_retry_o, 1'b0);
  endtask

  task automatic sw_cmd(input logic [2:0] cmd, input logic [7:0] a, input logic [7:0] d,
                        input bit late);
    frames.delete();
    @(posedge clk_i);
    // fields go with the go bit
    {ctrl_wr_i, ctrl_go_i, ctrl_cmd_i, ctrl_addr_i, ctrl_data_i} <= {2'h3, cmd, a, d};
    @(posedge clk_i);
    ctrl_wr_i <= 1'b0;
    if (late)
    begin
      repeat (20) @(posedge clk_i);
      {ctrl_wr_i, ctrl_cmd_i, ctrl_data_i} <= {1'b1, CMD_WRITE_MEM, 8'h00};
      @(posedge clk_i);
      ctrl_wr_i <= 1'b0;
    end
    wait_idle(1'b1);
  endtask

  task automatic chk_frames(input logic [23:0] e[$]);
    check(frames.size(), e.size());
    foreach (e[i])
      if (i < frames.size())
        check(frames[i], e[i]);
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_strap_off();
    do_reset(1'b0);
    repeat (20) @(posedge clk_i);
    #1;
    check(cfg_retry_o, 1'b0);
    check(frames.size() + cfg_q.size(), 0);
    $display("test strap_off done");
  endtask

  task automatic t_sig_bad();
    mdl.mem[0] = 8'h55;
    do_reset(1'b1);
    wait_idle(1'b0);
    chk_frames({fr(8'h18, OP_READ_MEM, SIG_ADDR)});
    check(cfg_q.size(), 0);
    $display("test sig_bad done");
  endtask

  task automatic t_load();
    logic [23:0] e[$];
    mdl.mem[0] = SIG_VALUE;
    for (int i = 0; i <= 4 * LOAD_DWORDS; i++)
    begin
      if (i > 0)
        mdl.mem[i] = 8'(8'h11 * i);
      e.push_back(fr(8'h18, OP_READ_MEM, 8'(i)));
    end
    do_reset(1'b1);
    repeat (50) @(posedge clk_i);
    #1;
    check(cfg_retry_o, 1'b1);
    wait_idle(1'b0);
    // the last config write pulse stands in the same cycle that retry drops
    repeat (2) @(posedge clk_i);
    chk_frames(e);
    check(cfg_q.size(), LOAD_DWORDS);
    foreach (cfg_q[j])
      check(cfg_q[j], {8'(4 * j), mdl.mem[4*j+4], mdl.mem[4*j+3], mdl.mem[4*j+2],
                       mdl.mem[4*j+1]});
    $display("test load done");
  endtask

  task automatic t_sw_cmds();
    logic [23:0] we;
    logic [23:0] rs;
    we = fr(8'h08, OP_WRITE_EN, 8'h00);
    rs = fr(8'h10, OP_READ_STATUS, 8'h00);
    sw_cmd(CMD_WRITE_STATUS, 8'h00, 8'h0C, 1'b0);
    chk_frames({we, fr(8'h10, OP_WRITE_STATUS, 8'h00), rs, rs, rs});
    sw_cmd(CMD_WRITE_MEM, 8'h20, 8'hC3, 1'b0);
    chk_frames({we, fr(8'h18, OP_WRITE_MEM, 8'h20), rs, rs, rs});
    check(mdl.mem[8'h20], 8'hC3);
    sw_cmd(CMD_READ_MEM, 8'h20, 8'h00, 1'b1);
    chk_frames({fr(8'h18, OP_READ_MEM, 8'h20)});
    check(ctrl_data_o, 8'hC3);
    sw_cmd(CMD_READ_STATUS, 8'h00, 8'h00, 1'b0);
    chk_frames({rs});
    check(ctrl_data_o, 8'h00);
    sw_cmd(CMD_WRITE_EN, 8'h00, 8'h00, 1'b0);
    chk_frames({we});
    sw_cmd(CMD_WRITE_DIS, 8'h00, 8'h00, 1'b0);
    chk_frames({fr(8'h08, OP_WRITE_DIS, 8'h00)});
    absent = 1'b1;
    sw_cmd(CMD_READ_MEM, 8'h05, 8'h00, 1'b0);
    check(ctrl_data_o, 8'hFF);
    absent = 1'b0;
    $display("test sw_cmds done");
  endtask

  initial
  begin
    t_strap_off();
    t_sig_bad();
    t_load();
    t_sw_cmds();
    close_out();
  end
endmodule // eeprom_config_loader_tb_top

bind eeprom_config_loader eeprom_loader_asserts #(.LOAD_DWORDS(LOAD_DWORDS),
  .HALF_DIV(HALF_DIV)) chk (.clk_i, .reset_i, .autoload_enable_pin_i, .eeprom_select_n_o,
  .eeprom_sck_o, .eeprom_serial_out_o, .eeprom_serial_in_i, .cfg_wr_o, .cfg_addr_o,
  .cfg_data_o, .cfg_retry_o, .ctrl_wr_i, .ctrl_go_i, .ctrl_cmd_i, .ctrl_addr_i,
  .ctrl_data_i, .ctrl_go_o, .ctrl_data_o);
`default_nettype wire
